// ### rtl/cascade_timer_params.svh
// constants for the cascaded 16-bit timer with clock-source selection
`ifndef CASCADE_TIMER_PARAMS_SVH
`define CASCADE_TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ADDR_CLK_SELECT 16'hffb6
`define ADDR_CTRL_STATUS 16'hffb7
`define ADDR_CNT_UPPER 16'hffb8
`define ADDR_CNT_LOWER 16'hffb9
`define ADDR_CMP_UPPER 16'hffba
`define ADDR_CMP_LOWER 16'hffbb
`define ADDR_IRQ_STATUS 16'hffbc
`define ADDR_IRQ_MASK 16'hffbd

// ----------------------------------------------------------------------------
// reset values and field codes
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CMP 16'hffff
`define BYTE_ALL_ONES 8'hff
`define BYTE_ONE 8'h01
`define SEL_FORBIDDEN 3'h3
`define SEL_DIV32 3'h4
`define SEL_DIV16 3'h5
`define SEL_DIV4 3'h6
`define SEL_SUB4 3'h7
`define SEL_INTERNAL_BIT 2
`define STAT_LOWER_OVF 0
`define STAT_UPPER_OVF 1
`define SUB_DIV_LAST 2'h3
`define PRESCALE_MIN_W 5

`endif

// ### rtl/cascade_timer_pkg.sv
// types shared by the cascaded timer
package cascade_timer_pkg;

  // layout of the clock-select control register
  typedef struct packed {
    logic rsv7;
    logic [2:0] upper_sel;
    logic rsv3;
    logic [2:0] lower_sel;
  } clk_select_t;

  // one-cycle enable pulses from the internal rate sources
  typedef struct packed {
    logic div32;
    logic div16;
    logic div4;
    logic sub4;
  } tick_t;

endpackage

// ### rtl/edge_pulse.sv
// rising-edge detector with optional two-stage synchronizer
`timescale 1ns/1ps
`default_nettype none
module edge_pulse #(
  parameter bit SYNC = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // level in, pulse out
  input wire logic level_i,
  output logic pulse_o
);

  logic meta;
  logic stable;
  logic prev;
  logic next_meta;
  logic next_stable;
  logic next_prev;

  // first stage feeds only the second; edge detect looks at the settled copy
  always_comb
  begin
    next_meta = SYNC ? level_i : 1'b0;
    next_stable = SYNC ? meta : level_i;
    next_prev = stable;
    pulse_o = stable & ~prev;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

endmodule // edge_pulse
`default_nettype wire

// ### rtl/cascaded_timer.sv
// cascaded 16-bit up-counter with per-half clock-source selection
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cascade_timer_params.svh"
module cascaded_timer #(
  parameter int PRESCALE_W = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // count sources and power state
  input wire logic ext_event_i,
  input wire logic subclk_i,
  input wire logic low_power_i,
  // results
  output logic [15:0] count_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------------
  // the /32 tap needs at least five prescaler bits
  generate
    if (PRESCALE_W < `PRESCALE_MIN_W)
    begin : g_bad_width
      $error("cascaded_timer: PRESCALE_W too small");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  cascade_timer_pkg::clk_select_t clk_sel;
  cascade_timer_pkg::clk_select_t next_clk_sel;
  cascade_timer_pkg::tick_t tick;
  logic [7:0] ctrl_status, next_ctrl_status;
  logic [7:0] cnt_hi, next_cnt_hi;
  logic [7:0] cnt_lo, next_cnt_lo;
  logic [15:0] cmp, next_cmp;
  logic [7:0] irq_stat, next_irq_stat;
  logic [7:0] irq_mask, next_irq_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic [PRESCALE_W-1:0] prescale, next_prescale;
  logic [1:0] sub_div, next_sub_div;
  logic ext_pulse;
  logic sub_edge;
  logic tick_lo, tick_hi, ovf_lo, ovf_hi;
  logic wr_lo, wr_hi, rd_stat;

  // --------------------------------------------------------------------------
  // source conditioning
  // --------------------------------------------------------------------------
  // the event pin is already synchronous, so only an edge detector is needed
  edge_pulse #(.SYNC(1'b0)) u_ext_edge (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .level_i(ext_event_i),
    .pulse_o(ext_pulse)
  );

  // subclock is asynchronous to clk_i; costs up to one clk period of jitter
  edge_pulse #(.SYNC(1'b1)) u_sub_edge (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .level_i(subclk_i),
    .pulse_o(sub_edge)
  );

  // free-running prescaler and subclock divider give one-cycle enables
  always_comb
  begin
    next_prescale = prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    next_sub_div = sub_edge ? sub_div + 2'h1 : sub_div;
    tick.div32 = &prescale[4:0];
    tick.div16 = &prescale[3:0];
    tick.div4 = &prescale[1:0];
    tick.sub4 = sub_edge && (sub_div == `SUB_DIV_LAST);
  end

  // map a select code to its enable; forbidden code counts nothing
  function automatic logic pick(input logic [2:0] sel,
                                input cascade_timer_pkg::tick_t t,
                                input logic alt,
                                input logic low_pwr);
    logic r;
    r = 1'b0;
    unique case (sel)
      `SEL_DIV32: r = t.div32 & ~low_pwr;
      `SEL_DIV16: r = t.div16 & ~low_pwr;
      `SEL_DIV4: r = t.div4 & ~low_pwr;
      `SEL_SUB4: r = t.sub4;
      `SEL_FORBIDDEN: r = 1'b0;
      default: r = alt;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  // a write to a half takes precedence and suppresses its overflow
  always_comb
  begin
    wr_lo = wr_i && (addr_i == `ADDR_CNT_LOWER);
    wr_hi = wr_i && (addr_i == `ADDR_CNT_UPPER);
    tick_lo = pick(clk_sel.lower_sel, tick, ext_pulse, low_power_i);
    ovf_lo = tick_lo && (cnt_lo == `BYTE_ALL_ONES) && !wr_lo;
    tick_hi = pick(clk_sel.upper_sel, tick, ovf_lo, low_power_i);
    ovf_hi = tick_hi && (cnt_hi == `BYTE_ALL_ONES) && !wr_hi;
    next_cnt_lo = cnt_lo;
    next_cnt_hi = cnt_hi;
    if (wr_lo)
      next_cnt_lo = wdata_i;
    else if (tick_lo)
      next_cnt_lo = cnt_lo + `BYTE_ONE;
    if (wr_hi)
      next_cnt_hi = wdata_i;
    else if (tick_hi)
      next_cnt_hi = cnt_hi + `BYTE_ONE;
  end

  // --------------------------------------------------------------------------
  // registers and read port
  // --------------------------------------------------------------------------
  // reads of the interrupt status clear it, but a same-cycle event still lands
  always_comb
  begin
    next_clk_sel = clk_sel;
    next_ctrl_status = ctrl_status;
    next_cmp = cmp;
    next_irq_mask = irq_mask;
    rd_stat = rd_i && (addr_i == `ADDR_IRQ_STATUS);
    if (wr_i)
    begin
      unique case (addr_i)
        `ADDR_CLK_SELECT: next_clk_sel = wdata_i;
        `ADDR_CTRL_STATUS: next_ctrl_status = wdata_i;
        `ADDR_CMP_UPPER: next_cmp[15:8] = wdata_i;
        `ADDR_CMP_LOWER: next_cmp[7:0] = wdata_i;
        `ADDR_IRQ_MASK: next_irq_mask = wdata_i;
        default: next_cmp = cmp;
      endcase
    end
    next_irq_stat = rd_stat ? `RST_BYTE : irq_stat;
    next_irq_stat[`STAT_LOWER_OVF] = next_irq_stat[`STAT_LOWER_OVF] | ovf_lo;
    next_irq_stat[`STAT_UPPER_OVF] = next_irq_stat[`STAT_UPPER_OVF] | ovf_hi;
    next_irq = |(next_irq_stat & next_irq_mask);
    next_rdata = `RST_BYTE;
    if (rd_i)
    begin
      unique case (addr_i)
        `ADDR_CLK_SELECT: next_rdata = clk_sel;
        `ADDR_CTRL_STATUS: next_rdata = ctrl_status;
        `ADDR_CNT_UPPER: next_rdata = cnt_hi;
        `ADDR_CNT_LOWER: next_rdata = cnt_lo;
        `ADDR_CMP_UPPER: next_rdata = cmp[15:8];
        `ADDR_CMP_LOWER: next_rdata = cmp[7:0];
        `ADDR_IRQ_STATUS: next_rdata = irq_stat;
        `ADDR_IRQ_MASK: next_rdata = irq_mask;
        default: next_rdata = `RST_BYTE; // unmapped reads return zero
      endcase
    end
  end

  // all state except the edge detectors' registered here; reset values are constants only
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clk_sel <= `RST_BYTE;
      ctrl_status <= `RST_BYTE;
      cnt_hi <= `RST_BYTE;
      cnt_lo <= `RST_BYTE;
      cmp <= `RST_CMP;
      irq_stat <= `RST_BYTE;
      irq_mask <= `RST_BYTE;
      rdata_o <= `RST_BYTE;
      irq_o <= 1'b0;
      count_o <= {`RST_BYTE, `RST_BYTE};
      prescale <= '0;
      sub_div <= '0;
    end
    else
    begin
      clk_sel <= next_clk_sel;
      ctrl_status <= next_ctrl_status;
      cnt_hi <= next_cnt_hi;
      cnt_lo <= next_cnt_lo;
      cmp <= next_cmp;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rdata_o <= next_rdata;
      irq_o <= next_irq;
      count_o <= {next_cnt_hi, next_cnt_lo};
      prescale <= next_prescale;
      sub_div <= next_sub_div;
    end
  end

endmodule // cascaded_timer
`default_nettype wire

// ### tb/cascaded_timer_checker.sv
// concurrent checks on the cascaded timer ports
`timescale 1ns/1ps
`default_nettype none
module cascaded_timer_checker (
  // clock, reset and register port
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // sources and results
  input wire logic ext_event_i,
  input wire logic subclk_i,
  input wire logic low_power_i,
  input wire logic [15:0] count_o,
  input wire logic irq_o
);
  logic [7:0] sel;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // --------------------------------------------------------------------------
  // select shadow and checks
  // --------------------------------------------------------------------------
  // shadow of the select register, so the source-dependent checks know the chosen sources
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sel <= 8'h00;
    else if (wr_i && addr_i == 16'hffb6)
      sel <= wdata_i;
  end
  // pin quiet long enough for a synchronized edge to have landed
  sequence sub_quiet;
    $stable(subclk_i) [*8];
  endsequence
  chk_reset_clear: assert property ($rose(rstn_i) |-> count_o == 16'h0000)
    else $error("count not clear after reset");
  chk_cascade_step: assert property ($past(sel[6:4]) < 3'h3 && !$past(wr_i) |->
    count_o[15:8] == $past(count_o[15:8]) + {7'h00, $past(count_o[7:0]) == 8'hff && count_o[7:0] == 8'h00})
    else $error("upper half missed a lower carry");
  chk_lower_asleep: assert property (low_power_i && $past(low_power_i) && sel[2] &&
    sel[1:0] != 2'h3 && !wr_i |=> $stable(count_o[7:0])) else $error("lower ran asleep");
  chk_upper_asleep: assert property (low_power_i && $past(low_power_i) && sel[6] &&
    sel[5:4] != 2'h3 && !wr_i |=> $stable(count_o[15:8])) else $error("upper ran asleep");
  chk_ext_edge: assert property ($rose(ext_event_i) && sel[2:0] < 3'h3 && !wr_i |->
    ##[1:3] $changed(count_o[7:0])) else $error("event edge not counted");
  chk_ext_idle: assert property (!ext_event_i [*4] ##0 (sel[2:0] < 3'h3 && !wr_i) |=>
    $stable(count_o[7:0])) else $error("lower counted with no event");
  chk_sub_idle: assert property (sub_quiet ##0 (sel[2:0] == 3'h7 && !wr_i) |=>
    $stable(count_o[7:0])) else $error("lower counted with quiet subclock");
  chk_single_step: assert property (!$past(wr_i) |->
    count_o[7:0] - $past(count_o[7:0]) <= 8'h01) else $error("lower stepped by more than one");
endmodule // cascaded_timer_checker
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the cascaded timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, irq_o;
  logic ext_event_i = 1'b0, subclk_i = 1'b0, low_power_i = 1'b0;
  logic [15:0] addr_i = 16'h0000, count_o, c0;
  logic [7:0] wdata_i = 8'h00, rdata_o, v;
  logic [31:0] seed = 32'h0000_e7f8;
  int bad_count = 0, checks_done = 0;
  // --------------------------------------------------------------------------
  // clock, design and helpers
  // --------------------------------------------------------------------------
  always #20 clk_i = ~clk_i;
  cascaded_timer cascaded_timer_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_event_i(ext_event_i),
    .subclk_i(subclk_i), .low_power_i(low_power_i), .count_o(count_o), .irq_o(irq_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // software never writes code 011, so it is moved to 100
  function automatic logic [2:0] legal(input logic [2:0] c);
    return (c == 3'h3) ? 3'h4 : c;
  endfunction
  function automatic int per(input int j);
    return (j == 0) ? 32 : (j == 1) ? 16 : 4;
  endfunction
  // halves count apart here, so a lower wrap must not carry into the upper byte
  function automatic logic [15:0] step2(input logic [15:0] c, input logic [7:0] d);
    return {c[15:8] + d, c[7:0] + d};
  endfunction
  // compare registers come up all ones, everything else clear
  function automatic logic [7:0] rst_val(input int i);
    return (i == 4 || i == 5) ? 8'hff : 8'h00;
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    #1;
    cmp("irq", {15'h0000, e}, {15'h0000, irq_o});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(16'hffb6 + 16'(i), rst_val(i));
    $display("test reset done");
    repeat (6)
    begin
      seed = xs(seed);
      v = {seed[15], legal(seed[14:12]), seed[11], legal(seed[10:8])};
      wr(16'hffb6, v);
      rd(16'hffb6, v);
      wr(16'hffbd, seed[23:16]);
      rd(16'hffbd, seed[23:16]);
    end
    $display("test storage done");
    // whole divider periods give a step count free of prescaler phase
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_i);
      low_power_i <= (k > 2);
      wr(16'hffb6, {2{1'b0, 3'h4 + 3'(k % 3)}});
      #1;
      c0 = count_o;
      repeat (8 * per(k % 3)) @(posedge clk_i);
      #1;
      cmp("rate", step2(c0, (k > 2) ? 8'h00 : 8'h08), count_o);
    end
    $display("test rates done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      low_power_i <= k[0];
      wr(16'hffb6, 8'h77);
      #1;
      c0 = count_o;
      // eight slow subclock periods, seven clk cycles each, give two /4 ticks
      repeat (8)
      begin
        repeat (4) @(posedge clk_i);
        subclk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        subclk_i <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      #1;
      cmp("subclock", step2(c0, 8'h02), count_o);
    end
    $display("test subclock done");
    @(posedge clk_i);
    low_power_i <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      seed = xs(seed);
      c0 = {(k == 2) ? 8'hff : seed[7:0], 8'hfe};
      wr(16'hffb6, {2{1'b0, 3'(k)}});
      wr(16'hffb8, c0[15:8]);
      wr(16'hffb9, c0[7:0]);
      repeat (3)
      begin
        @(posedge clk_i);
        ext_event_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
      end
      #1;
      cmp("cascade", c0 + 16'h0003, count_o);
    end
    $display("test cascade done");
    wr(16'hffbd, 8'h00);
    irq_is(1'b0);
    wr(16'hffbd, 8'h03);
    irq_is(1'b1);
    rd(16'hffbc, 8'h03);
    irq_is(1'b0);
    $display("test irq done");
    test_done;
  end
  // a hang costs a mismatch and still ends the run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done;
  end
endmodule // testbench
bind cascaded_timer cascaded_timer_checker cascaded_timer_checker_inst (.clk_i(clk_i),
  .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .ext_event_i(ext_event_i), .subclk_i(subclk_i),
  .low_power_i(low_power_i), .count_o(count_o), .irq_o(irq_o));
`default_nettype wire
